// [rtl/adcmx_pkg.sv]
package adcmx_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS   = 5000;          // 200 MHz system clock
  localparam int CONV_TYP_NS     = 3200;          // Typical conversion time
  localparam int CONV_MAX_NS     = 3700;          // Longest conversion time
  localparam int ACQ_TYP_NS      = 1680;          // Typical acquisition time
  localparam int RATE_KSPS       = 175;           // Guaranteed throughput
  // Cycle counts: least times round up, longest times round down
  localparam int CONV_CYCLES     = (CONV_TYP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_MAX_CYCLES = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACQ_CYCLES      = (ACQ_TYP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SAMPLE_CYCLES   = (1000000000 / RATE_KSPS) / CLK_PERIOD_PS;
  localparam int CONV_CNT_W      = 10;            // Wide enough for CONV_CYCLES

  // ****************************************************************
  // Data path
  // ****************************************************************
  localparam int RESULT_W   = 16;                 // Result word width
  localparam int FIFO_DEPTH = 8;                  // Result buffer depth
  localparam int CFG_W      = 7;                  // Configuration word width

  // ****************************************************************
  // Configuration word fields, first shifted bit is the top one
  // ****************************************************************
  localparam int CFG_SINGLE_DIFF_BIT   = 6;       // single_diff_select
  localparam int CFG_ODD_SIGN_BIT      = 5;       // odd_sign_select
  localparam int CFG_ADDR_HI_BIT       = 4;       // pair_addr_hi
  localparam int CFG_ADDR_LO_BIT       = 3;       // pair_addr_lo
  localparam int CFG_SHARED_MINUS_BIT  = 2;       // shared_minus_select
  localparam int CFG_POLARITY_BIT      = 1;       // polarity_select, 1 = unipolar
  localparam int CFG_SLEEP_BIT         = 0;       // sleep_request
  localparam logic [6:0] CFG_RESET     = 7'h00;   // Pair 0/1 differential, bipolar, awake
  localparam logic [2:0] SHARED_MINUS_CH = 3'h7;  // Channel that serves as common minus
  localparam logic [2:0] CFG_COUNT_FULL  = 3'h7;  // Bits in a whole configuration word

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,                                      // Strobe high, nothing converting
    ST_CONV,                                      // Conversion under way
    ST_NAP,                                       // Done, strobe still high
    ST_FRAME                                      // Strobe low, serial port open
  } adcmx_state_type;

endpackage

// [rtl/adcmx_fifo.sv]
`timescale 1ns/1ps
module adcmx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];                  // Word storage
  logic [AW-1:0]    wr_ptr;                       // Next slot to write
  logic [AW-1:0]    rd_ptr;                       // Oldest slot
  logic [AW:0]      count;                        // Words held
  logic [WIDTH-1:0] out_word;                     // Registered head word

  wire push = in_valid_in & in_ready_out;
  wire pop  = out_valid_out & out_ready_in;

  // Full and empty come straight from the count register
  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = out_word;

  // Pointers and count; a push and a pop together keep the count
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset, which keeps it a plain memory
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Head word register; follows the oldest entry, written through when empty
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      out_word <= '0;
    end else if (pop) begin
      out_word <= (count == (AW+1)'(1)) ? in_data_in
                : mem[(rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1];
    end else if (push && count == '0) begin
      out_word <= in_data_in;
    end
  end

endmodule

// [rtl/adcmx_ctrl.sv]
`timescale 1ns/1ps
// How it works
// (R1) Rising strobe starts a conversion
// (R2) Strobe low after conversion opens serial output
// (R3) Bipolar setting gives two's complement result
// (R4) Unipolar setting gives straight binary result
// (R5) Differential pairs by address, odd/sign swaps polarity
// (R6) Single-ended channel measured against ground
// (R7) Shared minus: channel seven is negative input
// (R8) Odd/sign picks odd or even channel group
// (R9) Both inputs sampled at one instant
// (R10) Conversion typically 3.2 us, at most 3.7
// (R11) Host allows about 1.68 us acquisition
// (R12) Throughput 175 ksps including acquisition
// (R13) Seven-bit configuration word in fixed order
// (R14) Strobe edges ignored while converting
// (R15) Sleep request bit puts device asleep
// (R16) Strobe high after conversion gives nap
// (R17) Capture on rising, shift MSB first after falling
// (R18) New word applies to the following conversion
module adcmx_ctrl (
  input  wire logic                           clk_sys_in,
  input  wire logic                           reset_in,
  input  wire logic                           frame_convert_strobe_in,
  input  wire logic                           shift_clk_in,
  input  wire logic                           serial_data_in,
  input  wire logic [adcmx_pkg::RESULT_W-1:0] core_code_in,
  output logic                                serial_data_out,
  output logic                                serial_data_oe_out,
  output logic      [2:0]                     pos_channel_out,
  output logic      [2:0]                     neg_channel_out,
  output logic                                neg_ground_out,
  output logic                                sample_track_out,
  output logic                                converting_out,
  output logic                                nap_out,
  output logic                                sleep_out,
  output logic                                buffer_full_out
);
  import adcmx_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic strobe_meta, strobe_sync, strobe_prev;    // Frame/convert strobe
  logic sck_meta,    sck_sync,    sck_prev;       // Shift clock
  logic sdi_meta,    sdi_sync;                    // Serial data in

  // Two sync flops per pin, a third on strobe and shift clock; the edge detectors read only the second and third
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      {strobe_meta, strobe_sync, strobe_prev} <= 3'h7;
      {sck_meta, sck_sync, sck_prev}          <= 3'h0;
      {sdi_meta, sdi_sync}                    <= 2'h0;
    end else begin
      {strobe_meta, strobe_sync, strobe_prev} <= {frame_convert_strobe_in, strobe_meta,
                                                   strobe_sync};
      {sck_meta, sck_sync, sck_prev}          <= {shift_clk_in, sck_meta, sck_sync};
      {sdi_meta, sdi_sync}                    <= {serial_data_in, sdi_meta};
    end
  end

  wire strobe_rise = strobe_sync & ~strobe_prev;
  wire strobe_fall = ~strobe_sync & strobe_prev;
  wire sck_rise    = sck_sync & ~sck_prev;
  wire sck_fall    = ~sck_sync & sck_prev;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  adcmx_state_type          state, next_state;    // Sequencer
  logic [CONV_CNT_W-1:0]    conv_cnt;             // Cycles left in conversion
  logic [CFG_W-1:0]         cfg_shift;            // Word being shifted in
  logic [2:0]               cfg_count;            // Bits captured this frame
  logic [CFG_W-1:0]         cfg_pending;          // Word waiting for next acquisition
  logic                     pending_valid;        // Pending word present
  logic [CFG_W-1:0]         cfg_active;           // Word steering the mux now
  logic [RESULT_W-1:0]      out_shift;            // Result shift register
  logic [2:0]               next_pos, next_neg;   // Decoded mux selection
  logic                     next_gnd;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic [RESULT_W-1:0]      fifo_out_data;

  // Converts the raw offset-binary core code to the requested format
  function automatic logic [RESULT_W-1:0] format_code(input logic [RESULT_W-1:0] raw,
                                                       input logic unipolar);
    format_code = unipolar ? raw : {~raw[RESULT_W-1], raw[RESULT_W-2:0]};
  endfunction

  // ****************************************************************
  // Sequencer decode
  // ****************************************************************
  wire cfg_whole   = (cfg_count == CFG_COUNT_FULL);                      // R13
  wire asleep      = cfg_active[CFG_SLEEP_BIT];
  wire can_start   = strobe_rise & ~asleep & fifo_in_ready;              // R1 R15
  wire conv_done   = (state == ST_CONV) && (conv_cnt == '0);             // R10
  wire frame_load  = (next_state == ST_FRAME) && (state != ST_FRAME);
  // Strobe already low at conversion end and buffer empty: the fresh result goes straight to the shifter
  wire direct_out  = conv_done & frame_load & ~fifo_out_valid;          // R2
  wire fifo_push   = conv_done & ~direct_out;
  wire fifo_pop    = frame_load & fifo_out_valid;
  wire [RESULT_W-1:0] result_word =
         format_code(core_code_in, cfg_active[CFG_POLARITY_BIT]);         // R3 R4

  // Next state; edges during a conversion are not looked at
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (strobe_fall) begin
          next_state = ST_FRAME;
        end else if (can_start) begin
          next_state = ST_CONV;                                          // R1
        end
      end
      ST_CONV: begin
        if (conv_done) begin                                             // R14
          next_state = strobe_sync ? ST_NAP : ST_FRAME;                  // R2 R16
        end
      end
      ST_NAP: begin
        if (strobe_fall) begin
          next_state = ST_FRAME;                                         // R2
        end
      end
      ST_FRAME: begin
        if (can_start) begin
          next_state = ST_CONV;                                          // R1
        end else if (strobe_rise) begin
          next_state = ST_IDLE;                                          // R15
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State and registered status outputs
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state              <= ST_IDLE;
      converting_out     <= 1'b0;
      nap_out            <= 1'b0;
      sample_track_out   <= 1'b1;
      serial_data_oe_out <= 1'b0;
    end else begin
      state              <= next_state;
      converting_out     <= (next_state == ST_CONV);
      nap_out            <= (next_state == ST_NAP);                      // R16
      sample_track_out   <= (next_state != ST_CONV);                     // R9
      serial_data_oe_out <= (next_state == ST_FRAME);                    // R2
    end
  end

  // Conversion timer; held loaded outside a conversion, counts down to zero
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      conv_cnt <= '0;
    end else if (state != ST_CONV) begin
      conv_cnt <= CONV_CNT_W'(CONV_CYCLES - 1);                          // R10
    end else if (conv_cnt != '0) begin
      conv_cnt <= conv_cnt - 1'b1;
    end
  end

  // ****************************************************************
  // Configuration word capture
  // ****************************************************************
  // Shift on rising shift clock edges while the frame is low; extra bits are dropped
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_shift <= CFG_RESET;
      cfg_count <= '0;
    end else if (strobe_fall) begin
      cfg_count <= '0;
    end else if (~strobe_sync && sck_rise && !cfg_whole) begin
      cfg_shift <= {cfg_shift[CFG_W-2:0], sdi_sync};                     // R13 R17
      cfg_count <= cfg_count + 1'b1;
    end
  end

  // A whole word waits until the conversion started with it has ended; with no start it applies at once
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_pending   <= CFG_RESET;
      pending_valid <= 1'b0;
      cfg_active    <= CFG_RESET;
    end else if (strobe_rise && state != ST_CONV && cfg_whole) begin
      if (can_start) begin
        cfg_pending   <= cfg_shift;                                      // R18
        pending_valid <= 1'b1;
      end else begin
        cfg_active    <= cfg_shift;                                      // R15
      end
    end else if (conv_done && pending_valid) begin
      cfg_active    <= cfg_pending;                                      // R18
      pending_valid <= 1'b0;
    end
  end

  // ****************************************************************
  // Input multiplexer decode
  // ****************************************************************
  // Address bits with odd/sign at the bottom name the positive channel
  assign next_pos = {cfg_active[CFG_ADDR_HI_BIT], cfg_active[CFG_ADDR_LO_BIT],
                     cfg_active[CFG_ODD_SIGN_BIT]};                      // R5 R6 R8
  // Shared minus wins, then ground for single-ended, else the pair partner
  assign next_neg = cfg_active[CFG_SHARED_MINUS_BIT] ? SHARED_MINUS_CH   // R7
                  : {next_pos[2:1], ~next_pos[0]};                       // R5
  assign next_gnd = ~cfg_active[CFG_SHARED_MINUS_BIT]
                  & cfg_active[CFG_SINGLE_DIFF_BIT];                     // R6

  // Mux selection registered so both inputs switch together
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pos_channel_out <= 3'h0;
      neg_channel_out <= 3'h1;
      neg_ground_out  <= 1'b0;
      sleep_out       <= 1'b0;
      buffer_full_out <= 1'b0;
    end else begin
      pos_channel_out <= next_pos;
      neg_channel_out <= next_neg;
      neg_ground_out  <= next_gnd;
      sleep_out       <= asleep;                                         // R15
      buffer_full_out <= ~fifo_in_ready;
    end
  end

  // ****************************************************************
  // Result buffer and serial output
  // ****************************************************************
  // A full buffer refuses new conversions; the host drains it frame by frame
  adcmx_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (result_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // Load at frame open (zeros if nothing buffered and no result just done), shift after falling edges
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      out_shift <= '0;
    end else if (frame_load) begin
      out_shift <= fifo_out_valid ? fifo_out_data : (direct_out ? result_word : '0); // R2
    end else if (state == ST_FRAME && sck_fall) begin
      out_shift <= {out_shift[RESULT_W-2:0], 1'b0};                      // R17
    end
  end

  assign serial_data_out = out_shift[RESULT_W-1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_conv_start: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R1
    (state == ST_IDLE || state == ST_FRAME) && can_start |=> state == ST_CONV)
    else $error("conversion did not start on strobe rise");

  a_frame_open: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R2
    state == ST_NAP && strobe_fall |=> serial_data_oe_out)
    else $error("serial port not enabled after strobe fall");

  a_bipolar_fmt: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R3
    fifo_push && !cfg_active[CFG_POLARITY_BIT] |->
      result_word == {~core_code_in[RESULT_W-1], core_code_in[RESULT_W-2:0]})
    else $error("bipolar result not two's complement");

  a_unipolar_fmt: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R4
    fifo_push && cfg_active[CFG_POLARITY_BIT] |-> result_word == core_code_in)
    else $error("unipolar result not straight binary");

  a_pair_sel: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R5
    !cfg_active[CFG_SHARED_MINUS_BIT] && !cfg_active[CFG_SINGLE_DIFF_BIT] |=>
      !neg_ground_out && (pos_channel_out ^ neg_channel_out) == 3'h1)
    else $error("differential pair selection wrong");

  a_single_gnd: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R6
    $changed(cfg_active) && cfg_active[CFG_SINGLE_DIFF_BIT]
      && !cfg_active[CFG_SHARED_MINUS_BIT] |=> neg_ground_out)
    else $error("single-ended input not against ground");

  a_shared_minus: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R7
    cfg_active[CFG_SHARED_MINUS_BIT] |=> neg_channel_out == 3'h7 && !neg_ground_out)
    else $error("shared minus not on channel seven");

  a_odd_group: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R8
    ##1 pos_channel_out[0] == $past(cfg_active[CFG_ODD_SIGN_BIT]))
    else $error("odd/sign does not pick channel group");

  a_hold_steady: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R9
    $rose(converting_out) |-> !sample_track_out && $fell(sample_track_out))
    else $error("sample and hold not switched with conversion");

  // Cycles of the running conversion; a counter, as the span is too long to unroll
  logic [CONV_CNT_W-1:0] conv_len;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      conv_len <= '0;
    end else begin
      conv_len <= converting_out ? conv_len + 1'b1 : '0;
    end
  end

  a_conv_time: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R10
    $fell(converting_out) |-> conv_len >= CONV_CNT_W'(CONV_CYCLES)
      && conv_len <= CONV_CNT_W'(CONV_MAX_CYCLES))
    else $error("conversion time out of range");

  a_rate_fits: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R12
    CONV_CYCLES + ACQ_CYCLES <= SAMPLE_CYCLES && CONV_CYCLES <= CONV_MAX_CYCLES)
    else $error("conversion plus acquisition exceeds sample period");

  a_no_restart: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R14
    state == ST_CONV && !conv_done |=> state == ST_CONV && $stable(cfg_active))
    else $error("conversion disturbed while running");

  a_sleep_blocks: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R15
    asleep && state != ST_CONV |=> state != ST_CONV)
    else $error("conversion started while asleep");

  a_nap_entry: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R16
    conv_done && strobe_sync |=> nap_out && !serial_data_oe_out)
    else $error("nap not entered with strobe high");

  a_msb_first: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R17
    state == ST_FRAME && !frame_load && sck_fall |=>
      serial_data_out == $past(out_shift[RESULT_W-2]))
    else $error("serial output not shifted after falling edge");

  a_cfg_defer: assert property (@(posedge clk_sys_in) disable iff (reset_in) // R18
    pending_valid && state == ST_CONV && !conv_done |=> $stable(cfg_active))
    else $error("new word applied before conversion end");

endmodule

// [test/adcmx_host.sv]
`timescale 1ns/1ps
// ****************************************************************
// Host serial controller model
// ****************************************************************
module adcmx_host (
  input  wire logic        clk_sys_in,
  input  wire logic        go_in,
  input  wire logic        short_in,
  input  wire logic [6:0]  cfg_in,
  input  wire logic        serial_data_in,
  output logic             strobe_out,
  output logic             shift_clk_out,
  output logic             serial_data_out,
  output logic [15:0]      result_out,
  output logic             done_out
);
  // One frame per go: shift word in, result out, then start a conversion
  initial begin
    strobe_out = 1'b1;
    shift_clk_out = 1'b0;
    serial_data_out = 1'b0;
    result_out = 16'h0000;
    done_out = 1'b0;
    forever begin
      @(negedge clk_sys_in);
      done_out = 1'b0;
      if (go_in) begin
        strobe_out = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        for (int i = 0; i < 16; i++) begin
          // Beyond seven bits the line toggles, as nothing should be read
          serial_data_out = (i < 7) ? cfg_in[6 - i] : ~serial_data_out;
          repeat (13) @(negedge clk_sys_in);
          shift_clk_out = 1'b1;
          result_out = {result_out[14:0], serial_data_in};
          repeat (12) @(negedge clk_sys_in);
          shift_clk_out = 1'b0;
        end
        // Released data line shows the inverse, never a stale level
        serial_data_out = ~serial_data_out;
        repeat (8) @(negedge clk_sys_in);
        strobe_out = 1'b1;
        done_out = 1'b1;
        if (short_in) begin
          // Short pulse: low again well before the first bit decision
          @(negedge clk_sys_in);
          done_out = 1'b0;
          repeat (9) @(negedge clk_sys_in);
          strobe_out = 1'b0;
        end
      end
    end
  end
endmodule

// [test/adcmx_tb_top.sv]
`timescale 1ns/1ps
// ****************************************************************
// Bench top: host model drives the device
// ****************************************************************
module adcmx_tb_top;
  import adcmx_pkg::*;
  logic        clk_sys_in = 1'b0;     // 200 MHz clock
  logic        reset_in = 1'b1;       // Held for two cycles
  logic        go = 1'b0;             // Frame request to the host
  logic [6:0]  cfg = 7'h00;           // Word for the next frame
  logic [15:0] core_code = 16'h0000;  // Raw code of the core
  logic        strobe, sck, sdi, sdo, conv, nap, sleep_request, gnd, done, oe, trk, full;
  logic        shrt = 1'b0;           // Short strobe pulse after the frame
  logic [2:0]  pos, neg;
  logic [15:0] res;
  logic [15:0] q[$];                  // Expected frame results
  logic [6:0]  act = 7'h00;           // Word steering the running conversion
  logic [15:0] pend_code = 16'h0000;  // Last converted code
  logic        pend_uni = 1'b1;       // First frame reads zeros, the unipolar form of a zero code
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  adcmx_host host (.clk_sys_in(clk_sys_in), .go_in(go), .cfg_in(cfg), .serial_data_in(sdo),
    .strobe_out(strobe), .shift_clk_out(sck), .serial_data_out(sdi), .result_out(res),
    .done_out(done), .short_in(shrt));
  adcmx_ctrl dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .frame_convert_strobe_in(strobe),
    .shift_clk_in(sck), .serial_data_in(sdi), .core_code_in(core_code), .serial_data_out(sdo),
    .serial_data_oe_out(oe), .pos_channel_out(pos), .neg_channel_out(neg),
    .neg_ground_out(gnd), .sample_track_out(trk), .converting_out(conv), .nap_out(nap),
    .sleep_out(sleep_request), .buffer_full_out(full));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One frame with word w; starts tells whether a conversion should follow
  // sh drops the strobe soon after the start, so the conversion ends inside a frame
  task automatic run(input logic [6:0] w, input logic starts, input logic sh);
    q.push_back(pend_uni ? pend_code : pend_code ^ 16'h8000);
    core_code = 16'($urandom);
    cfg = w;
    shrt = sh;
    go <= 1'b1;
    @(negedge clk_sys_in);
    go <= 1'b0;
    @(posedge done);
    if (starts) begin
      pend_code = core_code;
      pend_uni = act[CFG_POLARITY_BIT];
      repeat (6) @(negedge clk_sys_in);
      chk(16'(conv), 16'h1);
      chk(16'(trk), 16'h0);
      repeat (600) @(negedge clk_sys_in);
      chk(16'(conv), 16'h1);
      repeat (50) @(negedge clk_sys_in);
      chk(16'(conv), 16'h0);
      chk(16'(nap), sh ? 16'h0 : 16'h1);
      chk(16'(oe), sh ? 16'h1 : 16'h0);
      chk(16'(trk), 16'h1);
      chk(16'(full), 16'h0);
      chk(16'(pos), 16'({w[4], w[3], w[5]}));
      chk(16'(gnd), 16'(w[6] & ~w[2]));
      if (!(w[6] && !w[2])) chk(16'(neg), w[2] ? 16'h7 : 16'({w[4], w[3], ~w[5]}));
      chk(16'(sleep_request), 16'(w[0]));
      act = w;
    end else begin
      // Asleep: the rise is refused and the new word applies at once
      repeat (20) @(negedge clk_sys_in);
      chk(16'(conv), 16'h0);
      chk(16'(sleep_request), 16'h0);
      chk(16'(oe), 16'h0);
    end
  endtask
  // Result monitor and hang guard
  always @(posedge clk_sys_in) begin
    cyc++;
    if (done) chk(res, q.pop_front());
    if (sck) chk(16'(oe), 16'h1);
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(82));
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    // Every select code, ground and shared-minus alike, random format
    // One short strobe pulse for each of pair, ground and shared-minus codes
    for (int i = 0; i < 24; i++) begin
      run({i[3] | i[4], i[2:0], i[4], 1'($urandom), 1'b0}, 1'b1, i % 9 == 3);
    end
    run(7'h41, 1'b1, 1'b0);
    run(7'h40, 1'b0, 1'b0);
    end_sim();
  end
endmodule
